// [crbf_addr_if.sv]
// interface between register block and address arithmetic unit
`timescale 1ns/1ps
`default_nettype none
interface crbf_addr_if;
    import crbf_pkg::*;
    logic [WORD_W-1:0] disp;
    logic [WORD_W-1:0] baseVal;
    logic [WORD_W-1:0] pidxVal;
    logic [WORD_W-1:0] pcVal;
    logic [WORD_W-1:0] indWord;
    logic              useBase;
    logic              useIdx;
    logic              useRel;
    logic              indirect;
    logic [WORD_W-1:0] preAddr;
    logic [WORD_W-1:0] effAddr;
    modport regs (output disp, baseVal, pidxVal, pcVal, indWord, useBase, useIdx, useRel, indirect,
                  input preAddr, effAddr);
    modport unit (input disp, baseVal, pidxVal, pcVal, indWord, useBase, useIdx, useRel, indirect,
                  output preAddr, effAddr);
endinterface
`default_nettype wire

// [crbf_addr_unit.sv]
// address arithmetic unit: pre and post indexing around indirect fetch
`timescale 1ns/1ps
`default_nettype none
module crbf_addr_unit
    import crbf_pkg::*;
(
    // operands and results
    crbf_addr_if.unit au
);
    logic [WORD_W-1:0] baseSum;
    // base and relative terms go in before the indirect fetch
    always_comb begin
        baseSum = au.disp;
        if (au.useRel) begin
            baseSum = WORD_W'(baseSum + au.pcVal);
        end
        if (au.useBase) begin
            baseSum = WORD_W'(baseSum + au.baseVal);
        end
        if (au.useIdx && !au.indirect) begin
            baseSum = WORD_W'(baseSum + au.pidxVal);
        end
    end
    assign au.preAddr = baseSum;
    // post index applied to the fetched pointer
    assign au.effAddr = au.indirect ? (au.useIdx ? WORD_W'(au.indWord + au.pidxVal) : au.indWord)
                                    : baseSum;
endmodule
`default_nettype wire

// [crbf_ctl_model.sv]
// model of the control unit: sequencing and io requests
`timescale 1ns/1ps
`default_nettype none
module crbf_ctl_model
    import crbf_pkg::*;
(
    // clock
    input  wire logic         clock,
    // requests toward the register block
    output logic              pcStep,
    output logic              branch,
    output logic              subJump,
    output logic [WORD_W-1:0] branchTarget,
    output logic              ioLoad,
    output logic [WORD_W-1:0] ioIn
);
    // idle at time zero
    initial begin
        {pcStep, branch, subJump, ioLoad} = '0;
        {branchTarget, ioIn} = '1;
    end
    // one-cycle jump; target inverted once released, never trusted
    task automatic call(input logic [WORD_W-1:0] t);
        @(posedge clock);
        subJump <= 1'b1;
        branchTarget <= t;
        @(posedge clock);
        subJump <= 1'b0;
        branchTarget <= ~t;
    endtask
    // one-cycle branch, or one step of the counter when jump is low
    task automatic go(input logic jump, input logic [WORD_W-1:0] t);
        @(posedge clock);
        branch <= jump;
        pcStep <= !jump;
        branchTarget <= t;
        @(posedge clock);
        {branch, pcStep} <= 2'h0;
        branchTarget <= ~t;
    endtask
    // io word after some idle cycles, slow or prompt
    task automatic io(input logic [WORD_W-1:0] v, input int gap);
        repeat (gap) @(posedge clock);
        ioLoad <= 1'b1;
        ioIn <= v;
        @(posedge clock);
        ioLoad <= 1'b0;
        ioIn <= ~v;
    endtask
endmodule
`default_nettype wire

// [crbf_pkg.sv]
// package of constants, register map and encodings for the cpu register block
// Operation
// - seven 16-bit registers plus bus, interrupt registers
// - address holding register hidden from programs
// - accumulator is memory operand and io data
// - extension joins accumulator in double operations
// - temporary holds floating exponent or scratch
// - subroutine jump loads return link
// - post index added after indirect fetch
// - base added before indirect fetch
// - program counter sequences, branches, copies
// - other registers fully program controlled
// - register select may pick constant zero
// - six program accessible control flags
// - carry updated by listed add-type operations
// - dynamic overflow updated by listed operations
// - static overflow sticky until program clears
// - floating overflow sticky on divide by zero
// - one-bit accumulator for bit operations
// - shift link takes each discarded bit
// - flags set, tested singly, moved together
// - separate address arithmetic unit
// - 16-bit arithmetic on any register
// - double value: high accumulator, low extension
// - floating accumulator spans three registers
package crbf_pkg;
    localparam int WORD_W = 16;
    localparam int REG_NUM = 8;
    localparam int SEL_W = 3;
    // register select codes, zero code reads as zero
    localparam logic [2:0] SEL_ZERO = 3'h0;
    localparam logic [2:0] SEL_EXT = 3'h1;
    localparam logic [2:0] SEL_TMP = 3'h2;
    localparam logic [2:0] SEL_LINK = 3'h3;
    localparam logic [2:0] SEL_BASE = 3'h4;
    localparam logic [2:0] SEL_PIDX = 3'h5;
    localparam logic [2:0] SEL_ACC = 3'h6;
    localparam logic [2:0] SEL_PC = 3'h7;
    // flag word bit positions
    localparam int FL_CARRY = 0;
    localparam int FL_DOVF = 1;
    localparam int FL_SOVF = 2;
    localparam int FL_FOVF = 3;
    localparam int FL_ONEB = 4;
    localparam int FL_LINK = 5;
    localparam int FL_NUM = 6;
    // apb byte offsets
    localparam logic [7:0] OFS_ACC = 8'h00;
    localparam logic [7:0] OFS_EXT = 8'h04;
    localparam logic [7:0] OFS_TMP = 8'h08;
    localparam logic [7:0] OFS_LINK = 8'h0C;
    localparam logic [7:0] OFS_PIDX = 8'h10;
    localparam logic [7:0] OFS_BASE = 8'h14;
    localparam logic [7:0] OFS_PC = 8'h18;
    localparam logic [7:0] OFS_FLAGS = 8'h1C;
    localparam logic [7:0] OFS_ADDR = 8'h20;
    localparam logic [7:0] OFS_BUS0 = 8'h24;
    localparam logic [7:0] OFS_BUS3 = 8'h30;
    localparam logic [7:0] OFS_PRI0 = 8'h34;
    localparam logic [7:0] OFS_PRI1 = 8'h38;
    localparam logic [5:0] FLAGS_RST = 6'h00;
    // alu operation codes
    typedef enum logic [3:0] {
        OP_NONE = 4'h0, OP_ADD = 4'h1, OP_SUB = 4'h2, OP_REG_SUM = 4'h3,
        OP_REG_DIFF = 4'h4, OP_COPY = 4'h5, OP_IMM_ADD = 4'h6, OP_AND = 4'h7,
        OP_OR = 4'h8, OP_XOR = 4'h9, OP_PRODUCT = 4'hA, OP_SHIFT = 4'hB,
        OP_FLT = 4'hC, OP_FLT_DIV = 4'hD
    } crbf_op_t;
    // bit operation codes on a flag
    typedef enum logic [1:0] {
        BIT_SET = 2'h0, BIT_CLEAR = 2'h1, BIT_TEST = 2'h2, BIT_LOAD_K = 2'h3
    } crbf_bitop_t;
endpackage

// [crbf_register_block.sv]
// cpu register block with status flags, apb view and address unit
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module crbf_register_block
    import crbf_pkg::*;
(
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rstn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // register transfer from control unit
    input  wire logic              regWrite,
    input  wire logic [SEL_W-1:0]  dstSel,
    input  wire logic [SEL_W-1:0]  srcSel,
    input  wire logic [SEL_W-1:0]  src2Sel,
    output logic [WORD_W-1:0]      srcData,
    // arithmetic request
    input  wire logic              aluGo,
    input  wire crbf_op_t          aluOp,
    input  wire logic [WORD_W-1:0] memData,
    input  wire logic              useMem,
    input  wire logic              useCarryIn,
    // shift request on accumulator, optionally joined with extension
    input  wire logic              shiftGo,
    input  wire logic              shiftDouble,
    input  wire logic              shiftLeft,
    // double length and floating loads
    input  wire logic              dblLoad,
    input  wire logic [31:0]       dblData,
    input  wire logic              fltLoad,
    input  wire logic [47:0]       fltData,
    input  wire logic              fltCarry,
    output logic [31:0]            dblView,
    output logic [47:0]            fltView,
    // io transfer through accumulator
    input  wire logic              ioLoad,
    input  wire logic [WORD_W-1:0] ioIn,
    // sequencing
    input  wire logic              pcStep,
    input  wire logic              branch,
    input  wire logic [WORD_W-1:0] branchTarget,
    input  wire logic              subJump,
    // flag operations
    input  wire logic              bitGo,
    input  wire crbf_bitop_t       bitOp,
    input  wire logic [2:0]        bitSel,
    output logic                   bitResult,
    input  wire logic              flagsToAcc,
    input  wire logic              accToFlags,
    output logic [FL_NUM-1:0]      flags,
    output logic                   floatIrq,
    // address computation
    input  wire logic              addrGo,
    input  wire logic [WORD_W-1:0] disp,
    input  wire logic              useBase,
    input  wire logic              useIdx,
    input  wire logic              useRel,
    input  wire logic              indirect,
    input  wire logic [WORD_W-1:0] indWord,
    output logic [WORD_W-1:0]      preAddr,
    output logic [WORD_W-1:0]      memAddr
);
    logic [WORD_W-1:0] gpr_r [REG_NUM];   // index 0 unused: zero code
    logic [WORD_W-1:0] addrHold_r;
    logic [WORD_W-1:0] busReg_r [4];
    logic [WORD_W-1:0] priReg_r [2];
    logic [FL_NUM-1:0] flags_r;
    logic [WORD_W-1:0] aluRes;
    logic              aluCarry;
    logic              aluOvf;
    logic              shOut;
    logic [31:0]       shRes;
    logic [WORD_W-1:0] opA;
    logic [WORD_W-1:0] opB;
    logic              apbWr;
    logic [2:0]        apbIdx;
    logic              apbGpr;
    crbf_addr_if       au ();

    // zero code reads as zero, never the array slot
    function automatic logic [WORD_W-1:0] rdSel(input logic [SEL_W-1:0] s);
        return (s == SEL_ZERO) ? '0 : gpr_r[s];
    endfunction

    // apb decode of general register offsets
    function automatic logic isGpr(input logic [7:0] a);
        return a <= OFS_PC && a[1:0] == 2'h0;
    endfunction

    // map apb offset to select code
    always_comb begin
        apbIdx = SEL_ZERO;
        unique case (paddr)
            OFS_ACC:  apbIdx = SEL_ACC;
            OFS_EXT:  apbIdx = SEL_EXT;
            OFS_TMP:  apbIdx = SEL_TMP;
            OFS_LINK: apbIdx = SEL_LINK;
            OFS_PIDX: apbIdx = SEL_PIDX;
            OFS_BASE: apbIdx = SEL_BASE;
            OFS_PC:   apbIdx = SEL_PC;
            default:  apbIdx = SEL_ZERO;
        endcase
    end
    assign apbGpr = isGpr(paddr);
    assign apbWr = psel && penable && pwrite;

    // operands for the 16-bit unit, any register usable
    assign opA = rdSel(src2Sel);
    assign opB = useMem ? memData : rdSel(srcSel);
    assign srcData = rdSel(srcSel);

    // 16-bit arithmetic and logic with carry and overflow
    always_comb begin
        logic [WORD_W:0] sum;
        sum = '0;
        aluRes = '0;
        aluCarry = 1'b0;
        aluOvf = 1'b0;
        unique case (aluOp)
            OP_ADD, OP_REG_SUM, OP_IMM_ADD, OP_COPY: begin
                sum = (WORD_W+1)'({1'b0, opA}) + (WORD_W+1)'({1'b0, opB})
                    + (WORD_W+1)'(useCarryIn & flags_r[FL_CARRY]);
                aluRes = sum[WORD_W-1:0];
                aluCarry = sum[WORD_W];
                aluOvf = (opA[WORD_W-1] == opB[WORD_W-1]) && (aluRes[WORD_W-1] != opA[WORD_W-1]);
            end
            OP_SUB, OP_REG_DIFF: begin
                sum = (WORD_W+1)'({1'b0, opA}) + (WORD_W+1)'({1'b0, ~opB}) + (WORD_W+1)'(1);
                aluRes = sum[WORD_W-1:0];
                aluCarry = sum[WORD_W];
                aluOvf = (opA[WORD_W-1] != opB[WORD_W-1]) && (aluRes[WORD_W-1] != opA[WORD_W-1]);
            end
            OP_AND: aluRes = opA & opB;
            OP_OR:  aluRes = opA | opB;
            OP_XOR: aluRes = opA ^ opB;
            OP_PRODUCT: begin
                aluRes = WORD_W'($signed(opA) * $signed(opB));
                aluOvf = ($signed(opA) * $signed(opB)) != 32'($signed(aluRes));
            end
            default: aluRes = opA;
        endcase
    end

    // one shift step; double form joins accumulator high, extension low
    always_comb begin
        logic [31:0] w;
        w = shiftDouble ? {gpr_r[SEL_ACC], gpr_r[SEL_EXT]} : {gpr_r[SEL_ACC], 16'h0000};
        if (shiftLeft) begin
            shOut = w[31];
            shRes = {w[30:0], 1'b0};
        end else begin
            shOut = shiftDouble ? w[0] : w[16];
            shRes = shiftDouble ? {1'b0, w[31:1]} : {1'b0, w[31:17], 16'h0000};
        end
    end

    // general registers; no reset, contents undefined until loaded
    always_ff @(posedge clock) begin
        if (apbWr && apbGpr && apbIdx != SEL_ZERO) begin
            gpr_r[apbIdx] <= pwdata[WORD_W-1:0];
        end else if (dblLoad) begin
            gpr_r[SEL_ACC] <= dblData[31:16];
            gpr_r[SEL_EXT] <= dblData[15:0];
        end else if (fltLoad) begin
            gpr_r[SEL_TMP] <= fltData[47:32];
            gpr_r[SEL_ACC] <= fltData[31:16];
            gpr_r[SEL_EXT] <= fltData[15:0];
        end else if (shiftGo) begin
            gpr_r[SEL_ACC] <= shRes[31:16];
            if (shiftDouble) begin
                gpr_r[SEL_EXT] <= shRes[15:0];
            end
        end else if (ioLoad) begin
            gpr_r[SEL_ACC] <= ioIn;
        end else if (flagsToAcc) begin
            gpr_r[SEL_ACC] <= {{(WORD_W-FL_NUM){1'b0}}, flags_r};
        end else if (aluGo && dstSel != SEL_ZERO) begin
            gpr_r[dstSel] <= aluRes;
        end else if (regWrite && dstSel != SEL_ZERO) begin
            gpr_r[dstSel] <= rdSel(srcSel);
        end
        // sequencing on the counter; a subroutine jump keeps the return point
        if (subJump) begin
            gpr_r[SEL_LINK] <= WORD_W'(gpr_r[SEL_PC] + 16'h0001);
            gpr_r[SEL_PC] <= branchTarget;
        end else if (branch) begin
            gpr_r[SEL_PC] <= branchTarget;
        end else if (pcStep) begin
            gpr_r[SEL_PC] <= WORD_W'(gpr_r[SEL_PC] + 16'h0001);
        end
    end

    // hidden address holding register, written only by address unit
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            addrHold_r <= '0;
        end else if (addrGo) begin
            addrHold_r <= au.effAddr;
        end
    end

    // memory bus and priority registers, storage only here
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            busReg_r <= '{default: '0};
            priReg_r <= '{default: '0};
        end else if (apbWr) begin
            if (paddr >= OFS_BUS0 && paddr <= OFS_BUS3 && paddr[1:0] == 2'h0) begin
                busReg_r[2'(WORD_W'(paddr - OFS_BUS0) >> 2)] <= pwdata[WORD_W-1:0];
            end
            if (paddr == OFS_PRI0) begin
                priReg_r[0] <= pwdata[WORD_W-1:0];
            end
            if (paddr == OFS_PRI1) begin
                priReg_r[1] <= pwdata[WORD_W-1:0];
            end
        end
    end

    // flags: program moves first, then hardware updates override
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            flags_r <= FLAGS_RST;
        end else begin
            logic [FL_NUM-1:0] f;
            f = flags_r;
            if (apbWr && paddr == OFS_FLAGS) begin
                f = pwdata[FL_NUM-1:0];
            end
            if (accToFlags) begin
                f = gpr_r[SEL_ACC][FL_NUM-1:0];
            end
            if (bitGo) begin
                unique case (bitOp)
                    BIT_SET:    f[bitSel] = 1'b1;
                    BIT_CLEAR:  f[bitSel] = 1'b0;
                    BIT_TEST:   f[FL_ONEB] = flags_r[bitSel];
                    BIT_LOAD_K: f[bitSel] = flags_r[FL_ONEB];
                endcase
            end
            if (aluGo) begin
                unique case (aluOp)
                    OP_ADD, OP_SUB, OP_REG_SUM, OP_REG_DIFF, OP_COPY, OP_IMM_ADD: begin
                        f[FL_CARRY] = aluCarry;
                        f[FL_DOVF] = aluOvf;
                        f[FL_SOVF] = f[FL_SOVF] | aluOvf;
                    end
                    OP_PRODUCT: begin
                        f[FL_DOVF] = aluOvf;
                        f[FL_SOVF] = f[FL_SOVF] | aluOvf;
                    end
                    OP_FLT: f[FL_CARRY] = fltCarry;
                    OP_FLT_DIV: begin
                        f[FL_CARRY] = fltCarry;
                        f[FL_FOVF] = f[FL_FOVF] | (opB == '0);
                    end
                    default: f = f;
                endcase
            end
            if (shiftGo) begin
                f[FL_LINK] = shOut;
            end
            flags_r <= f;
        end
    end
    assign flags = flags_r;
    assign floatIrq = flags_r[FL_FOVF];
    assign bitResult = flags_r[FL_ONEB];
    assign dblView = {gpr_r[SEL_ACC], gpr_r[SEL_EXT]};
    assign fltView = {gpr_r[SEL_TMP], gpr_r[SEL_ACC], gpr_r[SEL_EXT]};

    // address unit hookup
    assign au.disp = disp;
    assign au.baseVal = gpr_r[SEL_BASE];
    assign au.pidxVal = gpr_r[SEL_PIDX];
    assign au.pcVal = gpr_r[SEL_PC];
    assign au.indWord = indWord;
    assign au.useBase = useBase;
    assign au.useIdx = useIdx;
    assign au.useRel = useRel;
    assign au.indirect = indirect;
    assign preAddr = au.preAddr;
    assign memAddr = addrHold_r;
    crbf_addr_unit u_addr (
        .au (au)
    );

    // apb read path, zero wait states; unmapped reads zero with error
    always_comb begin
        prdata = 32'h0000_0000;
        pslverr = 1'b0;
        if (apbGpr) begin
            prdata = {16'h0000, rdSel(apbIdx)};
        end else if (paddr == OFS_FLAGS) begin
            prdata = {26'h0, flags_r};
        end else if (paddr == OFS_ADDR) begin
            pslverr = psel && penable && pwrite;
            prdata = 32'h0000_0000;
        end else if (paddr >= OFS_BUS0 && paddr <= OFS_BUS3 && paddr[1:0] == 2'h0) begin
            prdata = {16'h0000, busReg_r[2'(WORD_W'(paddr - OFS_BUS0) >> 2)]};
        end else if (paddr == OFS_PRI0) begin
            prdata = {16'h0000, priReg_r[0]};
        end else if (paddr == OFS_PRI1) begin
            prdata = {16'h0000, priReg_r[1]};
        end else begin
            pslverr = psel && penable;
        end
    end
    assign pready = 1'b1;

    // checks
    sequence sovfSet_s;
        aluGo && aluOp == OP_ADD && aluOvf;
    endsequence
    sticky_sovf_a: assert property (@(posedge clock) disable iff (!rstn)
        sovfSet_s |=> flags_r[FL_SOVF]) else $error("static overflow not set");
    hold_sovf_a: assert property (@(posedge clock) disable iff (!rstn)
        flags_r[FL_SOVF] && !(apbWr && paddr == OFS_FLAGS) && !accToFlags && !(bitGo && bitSel == 3'(FL_SOVF))
        |=> flags_r[FL_SOVF]) else $error("static overflow lost");
    fdiv_zero_a: assert property (@(posedge clock) disable iff (!rstn)
        aluGo && aluOp == OP_FLT_DIV && opB == '0 |=> floatIrq) else $error("float overflow missed");
    link_ret_a: assert property (@(posedge clock) disable iff (!rstn)
        subJump |=> gpr_r[SEL_LINK] == WORD_W'($past(gpr_r[SEL_PC]) + 16'h0001)) else $error("bad link");
    zero_read_a: assert property (@(posedge clock) disable iff (!rstn)
        srcSel == SEL_ZERO |-> srcData == '0) else $error("zero reg nonzero");
    shift_link_a: assert property (@(posedge clock) disable iff (!rstn)
        shiftGo && shiftLeft |=> flags_r[FL_LINK] == $past(gpr_r[SEL_ACC][WORD_W-1])) else $error("link bit");
    dbl_load_a: assert property (@(posedge clock) disable iff (!rstn)
        dblLoad && !(apbWr && apbGpr) |=> dblView == $past(dblData)) else $error("double order");
    flag_word_a: assert property (@(posedge clock) disable iff (!rstn)
        flagsToAcc && !(apbWr && apbGpr) && !dblLoad && !fltLoad && !shiftGo && !ioLoad
        |=> gpr_r[SEL_ACC] == {10'h000, $past(flags_r)}) else $error("flag word");
    post_idx_a: assert property (@(posedge clock) disable iff (!rstn)
        addrGo && indirect && useIdx |=> memAddr == WORD_W'($past(indWord) + $past(gpr_r[SEL_PIDX])))
        else $error("post index");
endmodule
`default_nettype wire

// [test_cpu_register_block_flags.sv]
// self-checking testbench for the cpu register block
`timescale 1ns/1ps
`default_nettype none
module test_cpu_register_block_flags
    import crbf_pkg::*;
;
    logic        clock, rstn, psel, penable, pwrite, regWrite, aluGo, useMem, useCarryIn, err;
    logic        shiftGo, shiftDouble, shiftLeft, dblLoad, fltLoad, fltCarry, bitGo, flagsToAcc;
    logic        accToFlags, addrGo, useBase, useIdx, useRel, indirect, ioLoad, pcStep, branch;
    logic        subJump, pready, pslverr, bitResult, floatIrq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, dblData, dblView, rd;
    logic [47:0] fltData, fltView;
    logic [2:0]  dstSel, srcSel, src2Sel, bitSel;
    logic [15:0] memData, ioIn, branchTarget, disp, indWord, preAddr, memAddr, srcData;
    logic [5:0]  flags;
    crbf_op_t    aluOp;
    crbf_bitop_t bitOp;
    int          num_errors, num_checks;

    crbf_register_block uut (.*);
    crbf_ctl_model ctl (.*);

    // 100 MHz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask
    // apb transfer; holds everything until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // only the watchdog ends a wait that never sees pready
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // one arithmetic step on the accumulator with a memory operand
    task automatic alu(input crbf_op_t op, input logic [15:0] m);
        @(posedge clock);
        aluGo <= 1'b1;
        aluOp <= op;
        memData <= m;
        @(posedge clock);
        aluGo <= 1'b0;
        #1;
    endtask
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // watchdog far beyond the 150 or so cycles needed
    initial begin
        #100000;
        num_errors++;
        end_of_test();
    end
    initial begin
        {psel, penable, pwrite, regWrite, aluGo, useCarryIn, shiftGo, shiftDouble, shiftLeft} = '0;
        {dblLoad, fltLoad, fltCarry, bitGo, flagsToAcc, accToFlags, addrGo, useBase, useIdx} = '0;
        {useRel, indirect, paddr, pwdata, dblData, fltData, disp, indWord, memData, bitSel} = '0;
        useMem = 1'b1;
        {dstSel, srcSel, src2Sel} = {SEL_ACC, SEL_ZERO, SEL_ACC};
        aluOp = OP_NONE;
        bitOp = BIT_SET;
        rstn = 1'b0;
        repeat (10) @(posedge clock);
        rstn <= 1'b1;
        apb(0, OFS_FLAGS, 32'h0);
        chk("flags", 32'h0, rd);
        apb(1, OFS_ADDR, 32'h1234);
        chk("hidden wr err", 32'h1, 32'(err));
        apb(0, OFS_ADDR, 32'h0);
        chk("hidden", 32'h0, rd);
        for (int i = 0; i < 7; i++) apb(1, 8'(i * 4), 32'hA500 + i);
        for (int i = 0; i < 7; i++) begin
            apb(0, 8'(i * 4), 32'h0);
            chk("gpr", 32'hA500 + i, rd);
        end
        chk("dbl view", 32'hA500A501, dblView);
        chk("flt exp", 32'hA502, 32'(fltView[47:32]));
        @(posedge clock);
        dblLoad <= 1'b1;
        dblData <= 32'h12345678;
        @(posedge clock);
        dblLoad <= 1'b0;
        apb(0, OFS_EXT, 32'h0);
        chk("ext", 32'h5678, rd);
        $display("register test done");
        // carry, then overflow and one add without it: dynamic follows, static sticks
        apb(1, OFS_ACC, 32'hFFFF);
        alu(OP_ADD, 16'h0001);
        chk("carry", 32'h01, 32'(flags));
        apb(1, OFS_ACC, 32'h7FFF);
        alu(OP_ADD, 16'h0001);
        chk("ovf", 32'h06, 32'(flags));
        alu(OP_ADD, 16'h0001);
        chk("sticky", 32'h04, 32'(flags));
        alu(OP_FLT_DIV, 16'h0000);
        chk("fovf", 32'h0C, 32'(flags));
        chk("irq", 32'h1, 32'(floatIrq));
        // 0x8001 times 2 does not fit in 16 bits; then 2 minus 1 carries out
        alu(OP_PRODUCT, 16'h0002);
        chk("mpy ovf", 32'h0E, 32'(flags));
        alu(OP_SUB, 16'h0001);
        chk("sub carry", 32'h0D, 32'(flags));
        apb(1, OFS_FLAGS, 32'h0);
        bitSel <= 3'(FL_ONEB);
        bitGo <= 1'b1;
        @(posedge clock);
        bitGo <= 1'b0;
        flagsToAcc <= 1'b1;
        @(posedge clock);
        flagsToAcc <= 1'b0;
        apb(0, OFS_ACC, 32'h0);
        chk("flag word", 32'h10, rd);
        chk("k out", 32'h1, 32'(bitResult));
        apb(1, OFS_ACC, 32'h002B);
        accToFlags <= 1'b1;
        @(posedge clock);
        accToFlags <= 1'b0;
        #1;
        chk("acc to flags", 32'h2B, 32'(flags));
        $display("flag test done");
        // right shifts of 5: discarded bits 1, 0, 1
        apb(1, OFS_ACC, 32'h5);
        shiftGo <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        chk("link 0", 32'h0, 32'(flags[FL_LINK]));
        @(posedge clock);
        shiftGo <= 1'b0;
        #1;
        chk("link 1", 32'h1, 32'(flags[FL_LINK]));
        // one double left step: 0x8000_5678 becomes 0x0000_ACF0, top bit to link
        apb(1, OFS_ACC, 32'h8000);
        {shiftGo, shiftDouble, shiftLeft} <= 3'h7;
        @(posedge clock);
        shiftGo <= 1'b0;
        #1;
        chk("link 2", 32'h1, 32'(flags[FL_LINK]));
        chk("dbl shift", 32'h0000ACF0, dblView);
        ctl.io(16'hBEEF, 3);
        apb(0, OFS_ACC, 32'h0);
        chk("io acc", 32'hBEEF, rd);
        apb(1, OFS_PC, 32'h0100);
        ctl.call(16'h0200);
        apb(0, OFS_LINK, 32'h0);
        chk("link", 32'h0101, rd);
        apb(0, OFS_PC, 32'h0);
        chk("pc", 32'h0200, rd);
        // base 0xA505 before the fetch, post index 0xA504 after it
        {disp, indWord, useBase, useIdx, indirect, addrGo} <= {16'h0010, 16'h1000, 4'hF};
        @(posedge clock);
        addrGo <= 1'b0;
        #1;
        chk("pre addr", 32'hA515, 32'(preAddr));
        chk("eff addr", 32'hB504, 32'(memAddr));
        ctl.go(1'b0, 16'h0000);
        ctl.go(1'b1, 16'h0300);
        ctl.go(1'b0, 16'h0000);
        apb(0, OFS_PC, 32'h0);
        chk("pc seq", 32'h0301, rd);
        @(posedge clock);
        regWrite <= 1'b1;
        dstSel <= SEL_TMP;
        @(posedge clock);
        regWrite <= 1'b0;
        apb(0, OFS_TMP, 32'h0);
        chk("zero src", 32'h0, rd);
        chk("src data", 32'h0, 32'(srcData));
        // reset in mid run must clear flags left set above
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        apb(0, OFS_FLAGS, 32'h0);
        chk("flags rst", 32'h0, rd);
        chk("addr rst", 32'h0, 32'(memAddr));
        $display("sequencing test done");
        end_of_test();
    end
endmodule
`default_nettype wire
